// >>> core/clm_defs.vh
/*
 * Constants for the literal and move execution unit: opcode encodings,
 * addressing-mode codes and reset values.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef CLM_DEFS_VH
`define CLM_DEFS_VH

`define CLM_OP_NOP 4'h0
`define CLM_OP_LOAD_BANK 4'h1
`define CLM_OP_LOAD_PAGE 4'h2
`define CLM_OP_LOAD_ACC 4'h3
`define CLM_OP_STORE_FILE 4'h4
`define CLM_OP_STORE_IND 4'h5
`define CLM_OP_STORE_REL 4'h6
`define CLM_OP_LOAD_OPTION 4'h7
`define CLM_OP_SOFT_RESET 4'h8

`define CLM_MODE_PREINC 2'h0
`define CLM_MODE_PREDEC 2'h1
`define CLM_MODE_POSTINC 2'h2
`define CLM_MODE_POSTDEC 2'h3

`define CLM_FILE_IND0 7'h00
`define CLM_FILE_IND1 7'h01

`define CLM_BANK_RST 5'h00
`define CLM_PAGE_RST 7'h00
`define CLM_ACC_RST 8'h00
`define CLM_OPTION_RST 8'hff
`define CLM_PTR_RST 16'h0000
`define CLM_ADDR_RST 16'h0000
`define CLM_WDATA_RST 8'h00
`define CLM_FLAG_N_RST 1'b1
`define CLM_SOFT_RESET_CYCLES 4'h4

`endif

// >>> core/clm_ptr_unit.v
/*
 * Indirect pointer arithmetic: effective address and updated pointer value
 * for the pre/post increment/decrement modes and the signed-offset form.
 * Assumes the caller selects the pointer; purely combinational.
 */
`timescale 1ns/100ps
`include "clm_defs.vh"

module clm_ptr_unit (
  // Pointer and operation.
  input wire [15:0] ptr,
  input wire [1:0] pointer_mode_field,
  input wire rel_form,
  input wire [5:0] offset,
  // Results.
  output reg [15:0] eff_addr,
  output reg [15:0] nxt_ptr
);

  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [15:0] ptr_dec = ptr - 16'h0001;
  wire [15:0] ofs_ext = {{10{offset[5]}}, offset};

  always @* begin
    eff_addr = ptr;
    nxt_ptr = ptr;
    if (rel_form) begin
      eff_addr = ptr + ofs_ext;
      nxt_ptr = ptr;
    end else begin
      case (pointer_mode_field)
        `CLM_MODE_PREINC: begin
          eff_addr = ptr_inc;
          nxt_ptr = ptr_inc;
        end
        `CLM_MODE_PREDEC: begin
          eff_addr = ptr_dec;
          nxt_ptr = ptr_dec;
        end
        `CLM_MODE_POSTINC: begin
          eff_addr = ptr;
          nxt_ptr = ptr_inc;
        end
        default: begin
          eff_addr = ptr;
          nxt_ptr = ptr_dec;
        end
      endcase
    end
  end

endmodule // clm_ptr_unit

// >>> core/clm_exec.v
/*
 * Execution unit for the literal-load, accumulator-store, option-load,
 * no-operation and software-reset instructions of an 8-bit core.
 * Assumes a decoder presents one instruction per cycle on op_valid with its
 * operands already split out, and that status flags live elsewhere: this
 * unit drives none of them but soft_reset_flag_n. Memory writes leave as one-cycle strobes.
 */
`timescale 1ns/100ps
`include "clm_defs.vh"

module clm_exec (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Decoded instruction.
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [7:0] literal,
  input wire [6:0] file_addr,
  input wire ptr_sel,
  input wire [1:0] pointer_mode_field,
  input wire [5:0] rel_offset,
  // Power-on flag restore from the power control logic.
  input wire soft_reset_flag_set,
  // Architectural state.
  output reg [4:0] bank_select_reg,
  output reg [6:0] pc_high_latch,
  output reg [7:0] accumulator,
  output reg [7:0] option_reg,
  output reg [15:0] indirect_pointer0,
  output reg [15:0] indirect_pointer1,
  output reg soft_reset_flag_n,
  // Program counter advance.
  output reg pc_advance,
  // Data memory write strobe.
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  // Device reset request.
  output reg dev_reset_req
);

  reg [4:0] bank_ff, nxt_bank;
  reg [6:0] page_ff, nxt_page;
  reg [7:0] acc_ff, nxt_acc;
  reg [7:0] opt_ff, nxt_opt;
  reg [15:0] ptr0_ff, nxt_ptr0;
  reg [15:0] ptr1_ff, nxt_ptr1;
  reg ri_n_ff, nxt_ri_n;
  reg we_ff, nxt_we;
  reg [15:0] addr_ff, nxt_addr;
  reg [7:0] wdata_ff, nxt_wdata;
  reg adv_ff, nxt_adv;
  reg [3:0] rst_cnt_ff, nxt_rst_cnt;

  localparam ST_RUN = 1'b0;
  localparam ST_RESET = 1'b1;
  reg state_ff, nxt_state;

  // Returns the pointer named by a one-bit index.
  function [15:0] pick_ptr;
    input sel;
    input [15:0] p0;
    input [15:0] p1;
    begin
      pick_ptr = sel ? p1 : p0;
    end
  endfunction

  wire [15:0] sel_ptr = pick_ptr(ptr_sel, ptr0_ff, ptr1_ff);
  wire [15:0] eff_addr;
  wire [15:0] upd_ptr;

  clm_ptr_unit u_ptr (
    .ptr(sel_ptr),
    .pointer_mode_field(pointer_mode_field),
    .rel_form(op_code == `CLM_OP_STORE_REL),
    .offset(rel_offset),
    .eff_addr(eff_addr),
    .nxt_ptr(upd_ptr)
  );

  // True when a file address names one of the storage-less indirect windows.
  function is_window;
    input [6:0] fa;
    begin
      is_window = (fa == `CLM_FILE_IND0) || (fa == `CLM_FILE_IND1);
    end
  endfunction

  always @* begin
    nxt_bank = bank_ff;
    nxt_page = page_ff;
    nxt_acc = acc_ff;
    nxt_opt = opt_ff;
    nxt_ptr0 = ptr0_ff;
    nxt_ptr1 = ptr1_ff;
    nxt_ri_n = ri_n_ff | soft_reset_flag_set;
    nxt_we = 1'b0;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_adv = 1'b0;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (op_valid) begin
          nxt_adv = 1'b1;
          case (op_code)
            `CLM_OP_LOAD_BANK: nxt_bank = literal[4:0];
            `CLM_OP_LOAD_PAGE: nxt_page = literal[6:0];
            `CLM_OP_LOAD_ACC: nxt_acc = literal;
            `CLM_OP_STORE_FILE: begin
              nxt_we = 1'b1;
              nxt_wdata = acc_ff;
              if (is_window(file_addr)) begin
                // Window writes land at the pointer's target instead.
                nxt_addr = pick_ptr(file_addr[0], ptr0_ff, ptr1_ff);
              end else begin
                nxt_addr = {9'h000, file_addr};
              end
            end
            `CLM_OP_STORE_IND, `CLM_OP_STORE_REL: begin
              nxt_we = 1'b1;
              nxt_wdata = acc_ff;
              nxt_addr = eff_addr;
              // Pointer update has no path to any status flag.
              if (ptr_sel) begin
                nxt_ptr1 = upd_ptr;
              end else begin
                nxt_ptr0 = upd_ptr;
              end
            end
            `CLM_OP_LOAD_OPTION: nxt_opt = acc_ff;
            `CLM_OP_SOFT_RESET: begin
              nxt_ri_n = 1'b0;
              nxt_adv = 1'b0;
              nxt_rst_cnt = `CLM_SOFT_RESET_CYCLES;
              nxt_state = ST_RESET;
            end
            default: nxt_adv = 1'b1;
          endcase
        end
      end
      ST_RESET: begin
        // Core state returns to reset values; the cleared flag survives.
        nxt_bank = `CLM_BANK_RST;
        nxt_page = `CLM_PAGE_RST;
        nxt_acc = `CLM_ACC_RST;
        nxt_opt = `CLM_OPTION_RST;
        nxt_ptr0 = `CLM_PTR_RST;
        nxt_ptr1 = `CLM_PTR_RST;
        nxt_ri_n = 1'b0;
        nxt_rst_cnt = rst_cnt_ff - 4'h1;
        if (rst_cnt_ff == 4'h1) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      bank_ff <= `CLM_BANK_RST;
      page_ff <= `CLM_PAGE_RST;
      acc_ff <= `CLM_ACC_RST;
      opt_ff <= `CLM_OPTION_RST;
      ptr0_ff <= `CLM_PTR_RST;
      ptr1_ff <= `CLM_PTR_RST;
      ri_n_ff <= `CLM_FLAG_N_RST;
      we_ff <= 1'b0;
      addr_ff <= `CLM_ADDR_RST;
      wdata_ff <= `CLM_WDATA_RST;
      adv_ff <= 1'b0;
      rst_cnt_ff <= 4'h0;
      state_ff <= ST_RUN;
    end else begin
      bank_ff <= nxt_bank;
      page_ff <= nxt_page;
      acc_ff <= nxt_acc;
      opt_ff <= nxt_opt;
      ptr0_ff <= nxt_ptr0;
      ptr1_ff <= nxt_ptr1;
      ri_n_ff <= nxt_ri_n;
      we_ff <= nxt_we;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      adv_ff <= nxt_adv;
      rst_cnt_ff <= nxt_rst_cnt;
      state_ff <= nxt_state;
    end
  end

  always @* begin
    bank_select_reg = bank_ff;
    pc_high_latch = page_ff;
    accumulator = acc_ff;
    option_reg = opt_ff;
    indirect_pointer0 = ptr0_ff;
    indirect_pointer1 = ptr1_ff;
    soft_reset_flag_n = ri_n_ff;
    pc_advance = adv_ff;
    mem_we = we_ff;
    mem_addr = addr_ff;
    mem_wdata = wdata_ff;
    dev_reset_req = state_ff;
  end

endmodule // clm_exec

// >>> tb/clm_exec_sva.sv
/* Port assertions for the literal and move execution unit.
   Assumes it is bound to clm_exec and sees only its ports. */
`timescale 1ns/100ps
module clm_exec_sva (
  // Clock, reset and instruction.
  input wire clk,
  input wire rst,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [7:0] literal,
  input wire [6:0] file_addr,
  input wire ptr_sel,
  input wire [1:0] pointer_mode_field,
  input wire [5:0] rel_offset,
  // State and strobes.
  input wire [4:0] bank_select_reg,
  input wire [6:0] pc_high_latch,
  input wire [7:0] accumulator,
  input wire [7:0] option_reg,
  input wire [15:0] indirect_pointer0,
  input wire [15:0] indirect_pointer1,
  input wire soft_reset_flag_n,
  input wire pc_advance,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire dev_reset_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = op_valid && !dev_reset_req;
  wire [15:0] sx = {{10{rel_offset[5]}}, rel_offset};
  wire ind0 = tk && op_code == 4'h5 && !ptr_sel;
  wire ind1 = tk && op_code == 4'h5 && ptr_sel;
  AST_BANK: assert property (tk && op_code == 4'h1 |=>
    {3'h0, bank_select_reg} == ($past(literal) & 8'h1f)) else $error("bank load wrong");
  AST_PAGE: assert property (tk && op_code == 4'h2 |=>
    pc_high_latch == $past(literal[6:0])) else $error("page load wrong");
  AST_ACC: assert property (tk && op_code == 4'h3 |=>
    accumulator == $past(literal) && pc_advance) else $error("acc load wrong");
  AST_FILE: assert property (tk && op_code == 4'h4 |=>
    mem_we && mem_wdata == $past(accumulator)) else $error("file store wrong");
  AST_P0: assert property (ind0 && pointer_mode_field == 2'h0 |=>
    indirect_pointer0 == $past(indirect_pointer0) + 16'h1 && mem_addr == indirect_pointer0)
    else $error("preinc wrong");
  AST_P1: assert property (ind1 && pointer_mode_field == 2'h3 |=>
    mem_addr == $past(indirect_pointer1) && indirect_pointer1 == $past(indirect_pointer1) - 16'h1)
    else $error("postdec wrong");
  AST_REL: assert property (tk && op_code == 4'h6 && !ptr_sel |=>
    $stable(indirect_pointer0) && mem_addr == indirect_pointer0 + $past(sx))
    else $error("relative wrong");
  AST_WIN: assert property (tk && op_code == 4'h4 && file_addr == 7'h0 |=>
    mem_addr == $past(indirect_pointer0) && $stable(indirect_pointer0))
    else $error("window wrong");
  AST_OPT: assert property (tk && op_code == 4'h7 |=>
    option_reg == $past(accumulator)) else $error("option load wrong");
  AST_SRST: assert property (tk && op_code == 4'h8 |=>
    !soft_reset_flag_n ##0 dev_reset_req [*4] ##1 !dev_reset_req) else $error("soft reset wrong");
  AST_NOP: assert property (tk && op_code == 4'h0 |=>
    pc_advance && !mem_we && $stable(accumulator)) else $error("nop wrong");
  AST_REFUSE: assert property (op_valid && dev_reset_req |=>
    !pc_advance && !mem_we) else $error("op taken during reset");
endmodule // clm_exec_sva

bind clm_exec clm_exec_sva u_sva (.*);

// >>> tb/test_clm_exec.sv
/* Table-driven bench for the literal and move execution unit.
   Assumes clm_exec from core/ with its checker bound alongside. */
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module test_clm_exec;
  reg clk = 0;
  reg rst = 1;
  reg op_valid = 0;
  reg [3:0] op_code = 4'h0;
  reg [7:0] literal = 8'h0;
  reg [6:0] file_addr = 7'h0;
  reg ptr_sel = 0;
  reg [1:0] pointer_mode_field = 2'h0;
  reg [5:0] rel_offset = 6'h0;
  reg soft_reset_flag_set = 0;
  wire [4:0] bank_select_reg;
  wire [6:0] pc_high_latch;
  wire [7:0] accumulator;
  wire [7:0] option_reg;
  wire [15:0] indirect_pointer0;
  wire [15:0] indirect_pointer1;
  wire soft_reset_flag_n;
  wire pc_advance;
  wire mem_we;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata;
  wire dev_reset_req;
  wire [127:0] obv = {8'h0, mem_wdata, indirect_pointer1, indirect_pointer0, mem_addr,
    8'h0, option_reg, 8'h0, accumulator, 9'h0, pc_high_latch, 11'h0, bank_select_reg};
  // Rows: op, literal, file address, {pointer, mode}, offset, output index, expected.
  logic [46:0] rows [14] = '{
    {4'h3, 8'ha5, 7'h0, 3'h0, 6'h0, 3'h2, 16'h00a5},
    {4'h1, 8'hff, 7'h0, 3'h0, 6'h0, 3'h0, 16'h001f},
    {4'h2, 8'hff, 7'h0, 3'h0, 6'h0, 3'h1, 16'h007f},
    {4'h7, 8'h00, 7'h0, 3'h0, 6'h0, 3'h3, 16'h00a5},
    {4'h5, 8'h00, 7'h0, 3'h1, 6'h0, 3'h5, 16'hffff},
    {4'h5, 8'h00, 7'h0, 3'h6, 6'h0, 3'h4, 16'h0000},
    {4'h4, 8'h00, 7'h0, 3'h0, 6'h0, 3'h4, 16'hffff},
    {4'h5, 8'h00, 7'h0, 3'h0, 6'h0, 3'h5, 16'h0000},
    {4'h5, 8'h00, 7'h0, 3'h7, 6'h0, 3'h6, 16'h0000},
    {4'h6, 8'h00, 7'h0, 3'h0, 6'h20, 3'h4, 16'hffe0},
    {4'h4, 8'h00, 7'h5, 3'h0, 6'h0, 3'h7, 16'h00a5},
    {4'hf, 8'h11, 7'h0, 3'h0, 6'h0, 3'h2, 16'h00a5},
    {4'h4, 8'h00, 7'h1, 3'h0, 6'h0, 3'h4, 16'h0000},
    {4'h6, 8'h00, 7'h0, 3'h4, 6'h1f, 3'h4, 16'h001f}};
  int n_fail = 0;
  int check_count = 0;
  int n;
  logic [15:0] got;

  clm_exec u_dut (.*);

  initial forever #25 clk = ~clk;

  // Presents one instruction and holds it past one edge; the caller drops op_valid.
  task op(input [3:0] o, input [7:0] l, input [6:0] f, input [2:0] sm, input [5:0] k);
    op_valid = 1;
    op_code = o;
    literal = l;
    file_addr = f;
    {ptr_sel, pointer_mode_field} = sm;
    rel_offset = k;
    @(posedge clk);
    #1;
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 14; i++) begin
      op(rows[i][46:43], rows[i][42:35], rows[i][34:28], rows[i][27:25], rows[i][24:19]);
      got = obv[rows[i][18:16]*16 +: 16];
      `CHK(got, rows[i][15:0])
      $display("test %0d done", i);
    end
    op(4'h0, 8'h0, 7'h0, 3'h0, 6'h0);
    `CHK({pc_advance, mem_we}, 2'b10)
    $display("test nop done");
    op(4'h8, 8'h0, 7'h0, 3'h0, 6'h0);
    `CHK({dev_reset_req, soft_reset_flag_n}, 2'b10)
    // This load is held through the reset request and is only taken once it drops.
    op(4'h3, 8'h3c, 7'h0, 3'h0, 6'h0);
    n = 1;
    while (dev_reset_req && n < 10) begin
      `CHK(pc_advance, 1'b0)
      n++;
      @(posedge clk);
      #1;
    end
    if (n == 10)
      n_fail++;
    `CHK(n, 4)
    `CHK({accumulator, option_reg}, 16'h00ff)
    @(posedge clk);
    #1 op_valid = 0;
    `CHK(accumulator, 8'h3c)
    `CHK(soft_reset_flag_n, 1'b0)
    soft_reset_flag_set = 1;
    @(posedge clk);
    #1 soft_reset_flag_set = 0;
    `CHK(soft_reset_flag_n, 1'b1)
    $display("test soft reset done");
    rst = 1;
    @(posedge clk);
    #1 rst = 0;
    `CHK({bank_select_reg, pc_high_latch, accumulator, option_reg}, 28'h00000ff)
    `CHK({mem_addr, mem_wdata}, 24'h000000)
    `CHK({soft_reset_flag_n, dev_reset_req, pc_advance, mem_we}, 4'h8)
    `CHK({indirect_pointer0, indirect_pointer1}, 32'h00000000)
    $display("test reset done");
    give_verdict;
  end
endmodule // test_clm_exec
